/* ppd_cfg.svh */
// Constants and field layout of the partner, cable test and special registers
// Assumes a 16-bit management register port clocked by mclk
//
// How it works
// - Partner ability bit 10 is read-only, shows the partner's pause ability and resets to 0.
// - Partner ability bits 8..5 show partner 100FD, 100HD, 10FD, 10HD abilities, each resetting to 0.
// - Writing 1 to cable test bit 15 starts a test and hardware clears the bit when the test ends.
// - Once the start bit reads 0 after a launch, result, short flag and distance hold valid status.
// - Result bits 14..13 encode 00 normal, 01 open, 10 short, 11 failed, resetting to 00.
// - Read-only bit 12 is set when the short lies closer than ten meters.
// - Bits 8..0 hold the fault count, distance being about 0.4 m times the count.
// - Only one of the two ports implements the cable test register; the other reads it as zero.
// - Special bit 5 reads 1 when receive polarity is reversed, resetting to 0.
// - Special bit 2 is active-low power saving and resets to 1.
// - Special bit 1 puts the port in remote loopback and resets to 0.
// - In remote loopback the line receive data is turned around in the PMD/PMA and sent back out.
`ifndef PPD_CFG_SVH
`define PPD_CFG_SVH

`define PPD_ADDR_PARTNER   5'h05
`define PPD_ADDR_CABLE     5'h1d
`define PPD_ADDR_SPECIAL   5'h1f

`define PPD_LP_PAUSE       10
`define PPD_LP_ABIL_HI     8
`define PPD_LP_ABIL_LO     5

`define PPD_CT_START       15
`define PPD_CT_RES_HI      14
`define PPD_CT_RES_LO      13
`define PPD_CT_SHORT10     12
`define PPD_CT_CNT_HI      8
`define PPD_CT_CNT_LO      0

`define PPD_SP_POLRVS      5
`define PPD_SP_XOVER       4
`define PPD_SP_FORCE       3
`define PPD_SP_PSAVE       2
`define PPD_SP_RLOOP       1
`define PPD_SP_RSVD0       0

`define PPD_RESULT_RST     2'h0
`define PPD_PSAVE_RST      1'h1

`endif

/* ppd_pkg.sv */
// Types shared by the partner and diagnostic register bank
// Assumes ppd_cfg.svh holds the register addresses, bit positions and reset values
package ppd_pkg;
   typedef enum logic [1:0] {
      PPD_CT_IDLE = 2'b00,
      PPD_CT_RUN  = 2'b01
   } ppd_ct_state_t;

   typedef enum logic [1:0] {
      PPD_RES_NORMAL = 2'b00,
      PPD_RES_OPEN   = 2'b01,
      PPD_RES_SHORT  = 2'b10,
      PPD_RES_FAIL   = 2'b11
   } ppd_result_t;
endpackage : ppd_pkg

/* ppd_cable_test.sv */
// Cable test sequencer with result capture
// Assumes the analog tester answers with a one-cycle done pulse
`timescale 1ns/10ps
`include "ppd_cfg.svh"
module ppd_cable_test
   import ppd_pkg::*;
#(
   parameter int CNT_W = 9
) (
   input  wire logic             mclk,
   input  wire logic             reset,
   input  wire logic             start,
   input  wire logic             tdr_done,
   input  wire logic [1:0]       tdr_result,
   input  wire logic             tdr_short10,
   input  wire logic [CNT_W-1:0] tdr_count,
   output logic                  busy,
   output logic                  tdr_run,
   output logic [1:0]            result,
   output logic                  short10,
   output logic [CNT_W-1:0]      count
);
   ppd_ct_state_t    st_r, st_nxt;
   logic [1:0]       res_r, res_nxt;
   logic             sh_r, sh_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;

   always_comb begin
      st_nxt  = st_r;
      res_nxt = res_r;
      sh_nxt  = sh_r;
      cnt_nxt = cnt_r;
      case (st_r)
         PPD_CT_IDLE: begin
            if (start)
               st_nxt = PPD_CT_RUN;
         end
         PPD_CT_RUN: begin
            if (tdr_done) begin
               // Capture on the same edge the start bit drops so status is valid
               st_nxt  = PPD_CT_IDLE;
               res_nxt = tdr_result;
               sh_nxt  = tdr_short10;
               cnt_nxt = tdr_count;
            end
         end
         default: st_nxt = PPD_CT_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         st_r  <= PPD_CT_IDLE;
         res_r <= `PPD_RESULT_RST;
         sh_r  <= 1'b0;
         cnt_r <= '0;
      end else begin
         st_r  <= st_nxt;
         res_r <= res_nxt;
         sh_r  <= sh_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign busy    = (st_r == PPD_CT_RUN);
   assign tdr_run = busy;
   assign result  = res_r;
   assign short10 = sh_r;
   assign count   = cnt_r;
endmodule : ppd_cable_test

/* ppd_regs.sv */
// Partner ability, cable test and special control/status registers
// Assumes a synchronous management port: addr, wr, rd, wdata, rdata
`timescale 1ns/10ps
`include "ppd_cfg.svh"
module ppd_regs
   import ppd_pkg::*;
#(
   parameter bit HAS_CABLE_TEST = 1'b1,
   parameter int CNT_W          = 9
) (
   input  wire logic             mclk,
   input  wire logic             reset,
   input  wire logic [4:0]       mgmt_addr,
   input  wire logic             mgmt_wr,
   input  wire logic             mgmt_rd,
   input  wire logic [15:0]      mgmt_wdata,
   output logic [15:0]           mgmt_rdata,
   input  wire logic             lp_pause,
   input  wire logic [3:0]       lp_abil,
   input  wire logic             pol_reversed,
   input  wire logic             crossover_state,
   input  wire logic             tdr_done,
   input  wire logic [1:0]       tdr_result,
   input  wire logic             short_within_ten_meters,
   input  wire logic [CNT_W-1:0] tdr_count,
   output logic                  tdr_run,
   output logic                  force_link_pass,
   output logic                  power_save_en,
   output logic                  remote_loopback
);
   // ****************************************************
   // Partner ability snapshot
   // ****************************************************
   logic       lp_pause_r, lp_pause_nxt;
   logic [3:0] lp_abil_r, lp_abil_nxt;

   // Autonegotiation owns these; one flop keeps reads coherent
   always_comb begin
      lp_pause_nxt = lp_pause;
      lp_abil_nxt  = lp_abil;
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         lp_pause_r <= 1'b0;
         lp_abil_r  <= 4'h0;
      end else begin
         lp_pause_r <= lp_pause_nxt;
         lp_abil_r  <= lp_abil_nxt;
      end
   end

   // ****************************************************
   // Line status snapshot
   // ****************************************************
   logic       pol_r, pol_nxt;
   logic       xover_r, xover_nxt;

   // Polarity shows at every speed; only 10 Mb/s gives it meaning
   always_comb begin
      pol_nxt   = pol_reversed;
      xover_nxt = crossover_state;
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pol_r   <= 1'b0;
         xover_r <= 1'b0;
      end else begin
         pol_r   <= pol_nxt;
         xover_r <= xover_nxt;
      end
   end

   // ****************************************************
   // Special control bits
   // ****************************************************
   logic force_r, force_nxt;
   logic psave_r, psave_nxt;
   logic rloop_r, rloop_nxt;
   logic rsvd0_r, rsvd0_nxt;
   logic wr_sp, wr_ct;

   assign wr_sp = mgmt_wr && (mgmt_addr == `PPD_ADDR_SPECIAL);
   assign wr_ct = mgmt_wr && (mgmt_addr == `PPD_ADDR_CABLE) && HAS_CABLE_TEST;

   always_comb begin
      force_nxt = force_r;
      psave_nxt = psave_r;
      rloop_nxt = rloop_r;
      rsvd0_nxt = rsvd0_r;
      if (wr_sp) begin
         force_nxt = mgmt_wdata[`PPD_SP_FORCE];
         psave_nxt = mgmt_wdata[`PPD_SP_PSAVE];
         rloop_nxt = mgmt_wdata[`PPD_SP_RLOOP];
         // Kept as written; software must leave it 0
         rsvd0_nxt = mgmt_wdata[`PPD_SP_RSVD0];
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         force_r <= 1'b0;
         psave_r <= `PPD_PSAVE_RST;
         rloop_r <= 1'b0;
         rsvd0_r <= 1'b0;
      end else begin
         force_r <= force_nxt;
         psave_r <= psave_nxt;
         rloop_r <= rloop_nxt;
         rsvd0_r <= rsvd0_nxt;
      end
   end

   assign force_link_pass = force_r;
   assign power_save_en   = ~psave_r;
   // PMD/PMA turnaround is steered by this level
   assign remote_loopback = rloop_r;

   // ****************************************************
   // Cable test
   // ****************************************************
   logic             ct_busy;
   logic             ct_run;
   logic [1:0]       ct_result;
   logic             ct_short;
   logic [CNT_W-1:0] ct_count;
   logic             ct_start;

   // Start is honoured only while idle, inside the sequencer
   assign ct_start = wr_ct && mgmt_wdata[`PPD_CT_START];

   generate
      if (HAS_CABLE_TEST) begin : g_ct
         ppd_cable_test #(
            .CNT_W       (CNT_W)
         ) u_ct (
            .mclk        (mclk),
            .reset       (reset),
            .start       (ct_start),
            .tdr_done    (tdr_done),
            .tdr_result  (tdr_result),
            .tdr_short10 (short_within_ten_meters),
            .tdr_count   (tdr_count),
            .busy        (ct_busy),
            .tdr_run     (ct_run),
            .result      (ct_result),
            .short10     (ct_short),
            .count       (ct_count)
         );
      end else begin : g_no_ct
         // No tester on this port; saves the sequencer flops
         assign ct_busy   = 1'b0;
         assign ct_run    = 1'b0;
         assign ct_result = `PPD_RESULT_RST;
         assign ct_short  = 1'b0;
         assign ct_count  = '0;
      end
   endgenerate

   // Unsupported port never launches the tester
   assign tdr_run = ct_run && HAS_CABLE_TEST;

   // ****************************************************
   // Register images
   // ****************************************************
   logic [15:0] lp_word, ct_word, sp_word;

   // Reserved bits read 0, except special bit 0 which reads as written, so software may compare whole words
   always_comb begin
      lp_word = 16'h0000;
      lp_word[`PPD_LP_PAUSE] = lp_pause_r;
      lp_word[`PPD_LP_ABIL_HI:`PPD_LP_ABIL_LO] = lp_abil_r;
   end

   always_comb begin
      ct_word = 16'h0000;
      // Fields hold from one test's end to the next
      if (HAS_CABLE_TEST) begin
         ct_word[`PPD_CT_START] = ct_busy;
         ct_word[`PPD_CT_RES_HI:`PPD_CT_RES_LO] = ct_result;
         ct_word[`PPD_CT_SHORT10] = ct_short;
         ct_word[`PPD_CT_CNT_HI:`PPD_CT_CNT_LO] = ct_count;
      end
   end

   always_comb begin
      sp_word = 16'h0000;
      sp_word[`PPD_SP_POLRVS] = pol_r;
      sp_word[`PPD_SP_XOVER]  = xover_r;
      sp_word[`PPD_SP_FORCE]  = force_r;
      sp_word[`PPD_SP_PSAVE]  = psave_r;
      sp_word[`PPD_SP_RLOOP]  = rloop_r;
      sp_word[`PPD_SP_RSVD0]  = rsvd0_r;
   end

   // ****************************************************
   // Read data
   // ****************************************************
   logic [15:0] rd_nxt, rdata_r;

   // Data holds between reads so a slow host may sample late
   always_comb begin
      rd_nxt = rdata_r;
      if (mgmt_rd) begin
         case (mgmt_addr)
            `PPD_ADDR_PARTNER: rd_nxt = lp_word;
            `PPD_ADDR_CABLE:   rd_nxt = ct_word;
            `PPD_ADDR_SPECIAL: rd_nxt = sp_word;
            default:           rd_nxt = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset)
         rdata_r <= 16'h0000;
      else
         rdata_r <= rd_nxt;
   end

   assign mgmt_rdata = rdata_r;
endmodule : ppd_regs

/* ppd_regs_properties.sv */
// Checker for the partner, cable test and special register bank
// Assumes it is bound onto ppd_regs and sees only its ports
`timescale 1ns/10ps
module ppd_regs_properties
   import ppd_pkg::*;
#(
   parameter bit HAS_CABLE_TEST = 1'b1,
   parameter int CNT_W          = 9
) (
   input wire logic             mclk,
   input wire logic             reset,
   input wire logic [4:0]       mgmt_addr,
   input wire logic             mgmt_wr,
   input wire logic             mgmt_rd,
   input wire logic [15:0]      mgmt_wdata,
   input wire logic [15:0]      mgmt_rdata,
   input wire logic             lp_pause,
   input wire logic [3:0]       lp_abil,
   input wire logic             pol_reversed,
   input wire logic             crossover_state,
   input wire logic             tdr_done,
   input wire logic [1:0]       tdr_result,
   input wire logic             short_within_ten_meters,
   input wire logic [CNT_W-1:0] tdr_count,
   input wire logic             tdr_run,
   input wire logic             force_link_pass,
   input wire logic             power_save_en,
   input wire logic             remote_loopback
);
   // ********************
   // Properties
   // ********************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   logic wr_sp;
   assign wr_sp = mgmt_wr && mgmt_addr == 5'h1f;
   AST_FORCE: assert property (wr_sp |=> force_link_pass == $past(mgmt_wdata[3]))
      else $error("force link pass not taken from write");
   AST_PSAVE: assert property (wr_sp |=> power_save_en == !$past(mgmt_wdata[2]))
      else $error("power save enable not inverse of written bit");
   AST_LOOP: assert property (wr_sp |=> remote_loopback == $past(mgmt_wdata[1]))
      else $error("remote loopback not taken from write");
   AST_HOLD: assert property (!mgmt_wr |=> $stable({force_link_pass, power_save_en, remote_loopback}))
      else $error("control output changed without a write");
   // A read right after reset shows the reset snapshot, not the pins
   AST_RD_LP: assert property (mgmt_rd && mgmt_addr == 5'h05
      && !$past(reset) |=> mgmt_rdata == {5'h0, $past(lp_pause, 2), 1'b0,
      $past(lp_abil, 2), 5'h0})
      else $error("partner ability readback wrong");
   AST_RD_SP: assert property (mgmt_rd && mgmt_addr == 5'h1f
      && !$past(reset) |=> mgmt_rdata[15:4] == {10'h0,
      $past(pol_reversed, 2), $past(crossover_state, 2)})
      else $error("special status readback wrong");
   AST_START: assert property (HAS_CABLE_TEST && mgmt_wr && mgmt_addr == 5'h1d && mgmt_wdata[15] && !tdr_run |=> tdr_run)
      else $error("cable test did not start");
   AST_RUN: assert property (tdr_run && !tdr_done |=> tdr_run)
      else $error("cable test ended without done");
   AST_DONE: assert property (tdr_run && tdr_done |=> !tdr_run)
      else $error("cable test still running after done");
   AST_NO_CT: assert property (!HAS_CABLE_TEST |-> !tdr_run)
      else $error("cable test ran on port without it");
   cover property (tdr_run && tdr_done);
   cover property (wr_sp ##1 mgmt_rd);
   cover property (mgmt_rd && mgmt_addr == 5'h05);
endmodule : ppd_regs_properties

bind ppd_regs ppd_regs_properties #(.HAS_CABLE_TEST(HAS_CABLE_TEST),
   .CNT_W(CNT_W)) ppd_regs_properties_inst (.*);

/* testbench.sv */
// Self-checking bench for the partner, cable test and special registers
// Assumes ppd_regs with its checker bound; inputs change at falling edges
`timescale 1ns/10ps
module testbench;
   import ppd_pkg::*;
   logic        mclk, reset, mgmt_wr, mgmt_rd, lp_pause, pol_reversed;
   logic        crossover_state, tdr_done, short_within_ten_meters;
   logic        tdr_run, run2, force_link_pass, power_save_en, remote_loopback;
   logic [4:0]  mgmt_addr;
   logic [15:0] mgmt_wdata, mgmt_rdata, rd2, rdv, ex;
   logic [3:0]  lp_abil;
   logic [1:0]  tdr_result, rc;
   logic [8:0]  tdr_count;
   logic [34:0] rows [5];
   int          errors, check_count;

   ppd_regs ppd_regs_inst (.*);
   // Second port without cable test shares all inputs
   ppd_regs #(.HAS_CABLE_TEST(1'b0)) ppd_regs_nct_inst (.*,
      .mgmt_rdata(rd2), .tdr_run(run2), .force_link_pass(),
      .power_save_en(), .remote_loopback());

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [15:0] d);
      @(negedge mclk);
      mgmt_addr = a;
      mgmt_wdata = d;
      mgmt_wr = wr;
      mgmt_rd = !wr;
      @(negedge mclk);
      mgmt_wr = 1'b0;
      mgmt_rd = 1'b0;
      rdv = mgmt_rdata;
   endtask : bus

   task automatic wrap_up;
      if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   // Run is about 80 cycles; generous margin
   initial begin
      #20000;
      errors++;
      wrap_up();
   end

   initial begin
      {mgmt_wr, mgmt_rd, lp_pause, pol_reversed, crossover_state} = 5'h0;
      {tdr_done, short_within_ten_meters, mgmt_addr, lp_abil} = 11'h0;
      {mgmt_wdata, tdr_result, tdr_count} = 27'h0;
      // Rows: write data, expected readback, force/psave_en/loop
      rows = '{{16'h000e, 16'h000e, 3'b101}, {16'h0000, 16'h0000, 3'b010},
               {16'h0008, 16'h0008, 3'b110}, {16'h0004, 16'h0004, 3'b000},
               {16'hffc2, 16'h0002, 3'b011}};
      reset = 1'b1;
      repeat (2) @(negedge mclk);
      reset = 1'b0;
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, 5'h1f, rows[i][34:19]);
         chk({force_link_pass, power_save_en, remote_loopback}, rows[i][2:0]);
         bus(1'b0, 5'h1f, 16'h0);
         chk(rdv, rows[i][18:3]);
      end
      // ********************
      // Status and partner
      // ********************
      {pol_reversed, crossover_state} = 2'b10;
      bus(1'b0, 5'h1f, 16'h0);
      chk(rdv, 16'h0022);
      {pol_reversed, crossover_state} = 2'b01;
      bus(1'b0, 5'h1f, 16'h0);
      chk(rdv, 16'h0012);
      lp_pause = 1'b1;
      lp_abil = 4'ha;
      bus(1'b1, 5'h05, 16'hffff);
      bus(1'b0, 5'h05, 16'h0);
      chk(rdv, 16'h0540);
      lp_pause = 1'b0;
      lp_abil = 4'h5;
      bus(1'b0, 5'h05, 16'h0);
      chk(rdv, 16'h00a0);
      // ********************
      // Cable test, every result code
      // ********************
      for (int r = 0; r < 4; r++) begin
         rc = r[1:0];
         bus(1'b1, 5'h1d, 16'h8000);
         chk({14'h0, tdr_run, run2}, 16'h2);
         bus(1'b0, 5'h1d, 16'h0);
         chk({15'h0, rdv[15]}, 16'h1);
         @(negedge mclk);
         tdr_done = 1'b1;
         tdr_result = rc;
         short_within_ten_meters = ~rc[0];
         tdr_count = {rc, 7'h35};
         @(negedge mclk);
         tdr_done = 1'b0;
         chk({15'h0, tdr_run}, 16'h0);
         bus(1'b0, 5'h1d, 16'h0);
         ex = {1'b0, rc, ~rc[0], 3'h0, rc, 7'h35};
         chk(rdv, ex);
         chk(rd2, 16'h0);
      end
      // Done pulse while idle must not disturb held results
      @(negedge mclk);
      tdr_done = 1'b1;
      tdr_result = 2'h0;
      @(negedge mclk);
      tdr_done = 1'b0;
      bus(1'b0, 5'h1d, 16'h0);
      chk(rdv, ex);
      // Unmapped address: write dropped, read gives zero
      bus(1'b1, 5'h00, 16'hffff);
      bus(1'b0, 5'h00, 16'h0);
      chk(rdv, 16'h0);
      bus(1'b0, 5'h1f, 16'h0);
      chk(rdv, 16'h0012);
      // Second reset in mid-run
      reset = 1'b1;
      repeat (2) @(negedge mclk);
      reset = 1'b0;
      chk({force_link_pass, power_save_en, remote_loopback}, 16'h0);
      bus(1'b0, 5'h1f, 16'h0);
      chk(rdv, 16'h0014);
      bus(1'b0, 5'h1d, 16'h0);
      chk(rdv, 16'h0);
      wrap_up();
   end
endmodule : testbench
